// ---- core/telemetry_params.svh ----
// constants for the telemetry and identity command registers
// Functional notes
// - read word 8Ch gives current, 1 ms, read-only
// - current word: exponent 15:11, mantissa 10:0
// - phase FFh: summed current of all devices
// - other phase: current of selected device only
// - read word 8Dh gives temperature, 300 us, read-only
// - temperature word linear format, 1 degC base
// - phase FFh: hottest temperature of the stack
// - other phase: temperature of selected device
// - write to read-only sets fault, alerts host
// - read byte 98h gives fixed revision nibbles
// - 99h: three writable identity bytes in eeprom
// - 9Ah: three writable model bytes in eeprom
// - writing one clears a set status bit
`ifndef TELEMETRY_PARAMS_SVH
`define TELEMETRY_PARAMS_SVH

`define CMD_STATUS_BYTE    8'h78
`define CMD_STATUS_CML     8'h7e
`define CMD_IOUT           8'h8c
`define CMD_TEMP           8'h8d
`define CMD_REVISION       8'h98
`define CMD_MFR_IDENT      8'h99
`define CMD_MAKER_MODEL_BYTES      8'h9a

`define PHASE_ALL          8'hff
`define DEV_ADDR           7'h24
// revision nibbles: arbitrary neutral values
`define PART_ONE_REV       4'h1
`define PART_TWO_REV       4'h2

`define CML_IVC_BIT        7
`define STATUS_CML_BIT     1
`define BLOCK_LEN          8'h03
`define IDX_LAST_BLOCK     3'h6
`define IDX_MAX            3'h7
`define BITS_PER_BYTE      4'h8
`define FILL_BYTE          8'hff

`define CLK_PERIOD_NS      25
`define IOUT_REFRESH_NS    1000000
`define TEMP_REFRESH_NS    300000
`define CUR_EXP            5'h1e
`define TEMP_EXP           5'h00

`endif

// ---- core/telemetry_pkg.sv ----
// types shared by the telemetry and identity register files
package telemetry_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } bus_state_t;

    typedef enum logic [1:0] {
        NV_LOAD,
        NV_READY
    } nvm_state_t;

    typedef struct packed {
        logic [4:0]  exponent;
        logic [10:0] mantissa;
    } linear_word_t;

endpackage

// ---- core/nvm_if.sv ----
// link between the register file and the eeprom shadow
`timescale 1ns/1ps
interface nvm_if;
    logic        load_done;
    logic [23:0] ident_bytes;
    logic [23:0] model_bytes;
    logic        store_req;
    logic        store_model;
    logic [23:0] store_data;

    modport regs   (input load_done, input ident_bytes, input model_bytes,
                    output store_req, output store_model, output store_data);
    modport shadow (output load_done, output ident_bytes, output model_bytes,
                    input store_req, input store_model, input store_data);
endinterface

// ---- core/nvm_shadow.sv ----
// eeprom-backed copy of the identity and model bytes
`timescale 1ns/1ps
`include "telemetry_params.svh"
module nvm_shadow (
    input  wire logic        clk,
    input  wire logic        rst_n,
    nvm_if.shadow            nv,
    output logic             rd_req,
    output logic             wr_req,
    output logic [47:0]      wdata,
    input  wire logic [47:0] rdata,
    input  wire logic        ack
);
    telemetry_pkg::nvm_state_t st_ff;
    logic [23:0]               ident_ff;
    logic [23:0]               model_ff;
    logic                      dirty_ff;
    logic                      done_ff;
    logic                      req_ff;

    assign nv.load_done   = done_ff;
    assign nv.ident_bytes = ident_ff;
    assign nv.model_bytes = model_ff;
    // load request comes from its own flop so the pin never glitches
    assign rd_req         = req_ff;
    assign wr_req         = dirty_ff;
    assign wdata          = {model_ff, ident_ff};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff    <= telemetry_pkg::NV_LOAD;
            ident_ff <= 24'h000000;
            model_ff <= 24'h000000;
            dirty_ff <= 1'b0;
            done_ff  <= 1'b0;
            req_ff   <= 1'b1;
        end else begin
            case (st_ff)
                telemetry_pkg::NV_LOAD: begin
                    if (ack) begin
                        ident_ff <= rdata[23:0];
                        model_ff <= rdata[47:24];
                        done_ff  <= 1'b1;
                        req_ff   <= 1'b0;
                        st_ff    <= telemetry_pkg::NV_READY;
                    end
                end
                default: begin
                    if (nv.store_req && !nv.store_model) begin
                        ident_ff <= nv.store_data;
                    end
                    if (nv.store_req && nv.store_model) begin
                        model_ff <= nv.store_data;
                    end
                    // a new store during a pending one keeps the request up
                    dirty_ff <= nv.store_req | (dirty_ff & ~ack);
                end
            endcase
        end
    end
endmodule // nvm_shadow

// ---- core/pmbus_telemetry_ident_regs.sv ----
// management-bus slave with telemetry, revision and identity commands
`timescale 1ns/1ps
`include "telemetry_params.svh"
module pmbus_telemetry_ident_regs #(
    parameter int CUR_REFRESH_CYC  = `IOUT_REFRESH_NS / `CLK_PERIOD_NS,
    parameter int TEMP_REFRESH_CYC = `TEMP_REFRESH_NS / `CLK_PERIOD_NS
) (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic        SCL,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE_N,
    output logic             ALERT_N,
    input  wire logic [7:0]  PHASE,
    input  wire logic [10:0] CUR_PH0,
    input  wire logic [10:0] CUR_PH1,
    input  wire logic [10:0] TEMP_PH0,
    input  wire logic [10:0] TEMP_PH1,
    output logic             NVM_RD_REQ,
    output logic             NVM_WR_REQ,
    output logic [47:0]      NVM_WDATA,
    input  wire logic [47:0] NVM_RDATA,
    input  wire logic        NVM_ACK
);
    ////////////////////////////////////////////////////////////////////////////
    // functions

    // adds two mantissas; on overflow halves and bumps the exponent
    function automatic telemetry_pkg::linear_word_t lin_sum(
        input logic [4:0]  e,
        input logic [10:0] a,
        input logic [10:0] b
    );
        logic [11:0] s;
        s = {a[10], a} + {b[10], b};
        if (s[11] != s[10]) begin
            lin_sum = {5'(e + 5'h01), s[11:1]};
        end else begin
            lin_sum = {e, s[10:0]};
        end
    endfunction

    function automatic logic [7:0] rd_byte(
        input logic [7:0]  cmd,
        input logic [2:0]  k,
        input logic [15:0] word,
        input logic [7:0]  sbyte,
        input logic [7:0]  scml,
        input logic [23:0] ident,
        input logic [23:0] model
    );
        logic [23:0] blk;
        rd_byte = `FILL_BYTE;
        blk     = (cmd == `CMD_MAKER_MODEL_BYTES) ? model : ident;
        if (cmd == `CMD_IOUT || cmd == `CMD_TEMP) begin
            if (k == 3'h0) begin
                rd_byte = word[7:0];
            end else if (k == 3'h1) begin
                rd_byte = word[15:8];
            end
        end else if (cmd == `CMD_REVISION && k == 3'h0) begin
            rd_byte = {`PART_ONE_REV, `PART_TWO_REV};
        end else if (cmd == `CMD_STATUS_BYTE && k == 3'h0) begin
            rd_byte = sbyte;
        end else if (cmd == `CMD_STATUS_CML && k == 3'h0) begin
            rd_byte = scml;
        end else if (cmd == `CMD_MFR_IDENT || cmd == `CMD_MAKER_MODEL_BYTES) begin
            if (k == 3'h0) begin
                rd_byte = `BLOCK_LEN;
            end else if (k <= 3'h3) begin
                rd_byte = blk[8*(k-3'h1) +: 8];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and line events

    logic scl_m_ff, scl_s_ff, scl_q_ff;
    logic sda_m_ff, sda_s_ff, sda_q_ff;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            {scl_m_ff, scl_s_ff, scl_q_ff} <= 3'h7;
            {sda_m_ff, sda_s_ff, sda_q_ff} <= 3'h7;
        end else begin
            {scl_m_ff, scl_s_ff, scl_q_ff} <= {SCL, scl_m_ff, scl_s_ff};
            {sda_m_ff, sda_s_ff, sda_q_ff} <= {SDA_IN, sda_m_ff, sda_s_ff};
        end
    end

    wire scl_rise  = scl_s_ff & ~scl_q_ff;
    wire scl_fall  = ~scl_s_ff & scl_q_ff;
    wire start_det = scl_s_ff & scl_q_ff & sda_q_ff & ~sda_s_ff;
    wire stop_det  = scl_s_ff & scl_q_ff & ~sda_q_ff & sda_s_ff;

    ////////////////////////////////////////////////////////////////////////////
    // telemetry snapshots

    logic [15:0] cur_word_ff, temp_word_ff;
    logic [15:0] cur_cnt_ff, temp_cnt_ff;

    wire all_phases = (PHASE == `PHASE_ALL);
    wire pick_one   = PHASE[0];
    // the per-device words need no overflow check: one mantissa always fits
    wire telemetry_pkg::linear_word_t cur_sum = lin_sum(`CUR_EXP, CUR_PH0, CUR_PH1);
    wire [10:0] cur_one  = pick_one ? CUR_PH1 : CUR_PH0;
    wire [10:0] temp_one = pick_one ? TEMP_PH1 : TEMP_PH0;
    wire [10:0] temp_hot = ($signed(TEMP_PH1) > $signed(TEMP_PH0)) ? TEMP_PH1 : TEMP_PH0;
    wire [4:0]  current_exponent     = all_phases ? cur_sum.exponent : `CUR_EXP;
    wire [10:0] current_mantissa     = all_phases ? cur_sum.mantissa : cur_one;
    wire [4:0]  temperature_exponent = `TEMP_EXP;
    wire [10:0] temperature_mantissa = all_phases ? temp_hot : temp_one;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cur_cnt_ff   <= 16'h0000;
            temp_cnt_ff  <= 16'h0000;
            cur_word_ff  <= 16'h0000;
            temp_word_ff <= 16'h0000;
        end else begin
            cur_cnt_ff  <= (cur_cnt_ff == 16'h0000) ? 16'(CUR_REFRESH_CYC - 1)
                                                    : 16'(cur_cnt_ff - 16'h0001);
            temp_cnt_ff <= (temp_cnt_ff == 16'h0000) ? 16'(TEMP_REFRESH_CYC - 1)
                                                     : 16'(temp_cnt_ff - 16'h0001);
            if (cur_cnt_ff == 16'h0000) begin
                cur_word_ff <= {current_exponent, current_mantissa};
            end
            if (temp_cnt_ff == 16'h0000) begin
                temp_word_ff <= {temperature_exponent, temperature_mantissa};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // eeprom shadow

    nvm_if nv ();

    nvm_shadow u_shadow (
        .clk    (CLK),
        .rst_n  (RSTN),
        .nv     (nv.shadow),
        .rd_req (NVM_RD_REQ),
        .wr_req (NVM_WR_REQ),
        .wdata  (NVM_WDATA),
        .rdata  (NVM_RDATA),
        .ack    (NVM_ACK)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus protocol engine

    telemetry_pkg::bus_state_t st_ff, nxt_st;
    logic [3:0]  bit_cnt_ff, nxt_bit;
    logic [7:0]  shift_ff, nxt_shift;
    logic [2:0]  idx_ff, nxt_idx;
    logic [7:0]  cmd_ff, nxt_cmd;
    logic        rd_ff, nxt_rd;
    logic        take_ff, nxt_take;
    logic        oe_n_ff, nxt_oe_n;
    logic [23:0] blk_ff, nxt_blk;
    logic [7:0]  cnt_ff, nxt_cnt;
    logic [15:0] hold_ff, nxt_hold;
    logic        ivc_ff, alert_n_ff;
    logic        ivc_set, ivc_clr, commit;

    wire [7:0] status_cml  = {ivc_ff, 7'h00};
    wire [7:0] status_byte = 8'(ivc_ff) << `STATUS_CML_BIT;
    wire       is_mfr      = (cmd_ff == `CMD_MFR_IDENT) || (cmd_ff == `CMD_MAKER_MODEL_BYTES);
    wire       is_ro       = (cmd_ff == `CMD_IOUT) || (cmd_ff == `CMD_TEMP)
                             || (cmd_ff == `CMD_REVISION);
    wire [2:0] idx_inc     = (idx_ff == `IDX_MAX) ? idx_ff : 3'(idx_ff + 3'h1);
    wire [7:0] tx_byte     = rd_byte(cmd_ff, idx_ff, hold_ff, status_byte, status_cml,
                                     nv.ident_bytes, nv.model_bytes);
    wire       addr_hit    = (shift_ff[7:1] == `DEV_ADDR);
    // identity reads are refused until the eeprom copy has arrived
    wire       rd_allowed  = !(is_mfr && !nv.load_done);

    assign nv.store_req   = commit;
    assign nv.store_model = (cmd_ff == `CMD_MAKER_MODEL_BYTES);
    assign nv.store_data  = blk_ff;

    always_comb begin
        nxt_st = st_ff;  nxt_bit = bit_cnt_ff;  nxt_shift = shift_ff;
        nxt_idx = idx_ff;  nxt_cmd = cmd_ff;  nxt_rd = rd_ff;  nxt_take = take_ff;
        nxt_oe_n = oe_n_ff;  nxt_blk = blk_ff;  nxt_cnt = cnt_ff;  nxt_hold = hold_ff;
        ivc_set = 1'b0;  ivc_clr = 1'b0;  commit = 1'b0;
        if (start_det) begin
            nxt_st = telemetry_pkg::ST_RX;  nxt_bit = 4'h0;  nxt_idx = 3'h0;  nxt_oe_n = 1'b1;
        end else if (stop_det) begin
            // a block write lands only when count and length are both three
            commit   = is_mfr && !rd_ff && nv.load_done && (idx_ff == `IDX_LAST_BLOCK)
                       && (cnt_ff == `BLOCK_LEN);
            nxt_st   = telemetry_pkg::ST_IDLE;
            nxt_oe_n = 1'b1;
        end else begin
            case (st_ff)
                telemetry_pkg::ST_RX: begin
                    if (scl_rise) begin
                        nxt_shift = {shift_ff[6:0], sda_s_ff};
                        nxt_bit   = 4'(bit_cnt_ff + 4'h1);
                    end else if (scl_fall && bit_cnt_ff == `BITS_PER_BYTE) begin
                        nxt_bit  = 4'h0;
                        nxt_st   = telemetry_pkg::ST_RX_ACK;
                        nxt_take = 1'b1;
                        if (idx_ff == 3'h0) begin
                            nxt_rd   = shift_ff[0];
                            nxt_take = addr_hit && (!shift_ff[0] || rd_allowed);
                            nxt_hold = (cmd_ff == `CMD_IOUT) ? cur_word_ff : temp_word_ff;
                        end else if (idx_ff == 3'h1) begin
                            nxt_cmd = shift_ff;
                        end else begin
                            ivc_set = is_ro && (idx_ff == 3'h2);
                            if (cmd_ff == `CMD_STATUS_CML) begin
                                ivc_clr = shift_ff[`CML_IVC_BIT];
                            end
                            if (cmd_ff == `CMD_STATUS_BYTE) begin
                                ivc_clr = shift_ff[`STATUS_CML_BIT];
                            end
                            if (idx_ff == 3'h2) begin
                                nxt_cnt = shift_ff;
                            end else begin
                                nxt_blk = {shift_ff, blk_ff[23:8]};
                            end
                        end
                        nxt_oe_n = ~nxt_take;
                    end
                end
                telemetry_pkg::ST_RX_ACK: begin
                    if (scl_fall) begin
                        nxt_idx = idx_inc;
                        if (!take_ff) begin
                            nxt_st   = telemetry_pkg::ST_IDLE;
                            nxt_oe_n = 1'b1;
                        end else if (rd_ff) begin
                            nxt_st    = telemetry_pkg::ST_TX;
                            nxt_shift = rd_byte(cmd_ff, 3'h0, hold_ff, status_byte,
                                                status_cml, nv.ident_bytes, nv.model_bytes);
                            nxt_oe_n  = nxt_shift[7];
                            nxt_idx   = 3'h1;
                        end else begin
                            nxt_st   = telemetry_pkg::ST_RX;
                            nxt_oe_n = 1'b1;
                        end
                    end
                end
                telemetry_pkg::ST_TX: begin
                    if (scl_rise) begin
                        nxt_bit = 4'(bit_cnt_ff + 4'h1);
                    end else if (scl_fall) begin
                        if (bit_cnt_ff == `BITS_PER_BYTE) begin
                            nxt_bit  = 4'h0;
                            nxt_st   = telemetry_pkg::ST_TX_ACK;
                            nxt_oe_n = 1'b1;
                        end else begin
                            nxt_shift = {shift_ff[6:0], 1'b1};
                            nxt_oe_n  = shift_ff[6];
                        end
                    end
                end
                telemetry_pkg::ST_TX_ACK: begin
                    if (scl_rise && sda_s_ff) begin
                        nxt_st = telemetry_pkg::ST_IDLE;
                    end else if (scl_fall) begin
                        nxt_st    = telemetry_pkg::ST_TX;
                        nxt_shift = tx_byte;
                        nxt_oe_n  = tx_byte[7];
                        nxt_idx   = idx_inc;
                    end
                end
                default: begin
                    nxt_st = telemetry_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // a fault raised in the same cycle as a clear stays set
    wire nxt_ivc = ivc_set | (ivc_ff & ~ivc_clr);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_ff      <= telemetry_pkg::ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff   <= 8'h00;
            idx_ff     <= 3'h0;
            cmd_ff     <= 8'h00;
            rd_ff      <= 1'b0;
            take_ff    <= 1'b0;
            oe_n_ff    <= 1'b1;
            blk_ff     <= 24'h000000;
            cnt_ff     <= 8'h00;
            hold_ff    <= 16'h0000;
            ivc_ff     <= 1'b0;
            alert_n_ff <= 1'b1;
        end else begin
            st_ff      <= nxt_st;
            bit_cnt_ff <= nxt_bit;
            shift_ff   <= nxt_shift;
            idx_ff     <= nxt_idx;
            cmd_ff     <= nxt_cmd;
            rd_ff      <= nxt_rd;
            take_ff    <= nxt_take;
            oe_n_ff    <= nxt_oe_n;
            blk_ff     <= nxt_blk;
            cnt_ff     <= nxt_cnt;
            hold_ff    <= nxt_hold;
            ivc_ff     <= nxt_ivc;
            alert_n_ff <= ~nxt_ivc;
        end
    end

    // open-drain: the pad only ever pulls low
    assign SDA_OUT  = 1'b0;
    assign SDA_OE_N = oe_n_ff;
    assign ALERT_N  = alert_n_ff;

endmodule // pmbus_telemetry_ident_regs

// ---- test/eeprom_model.sv ----
// eeprom model behind the identity shadow, prompt or slow
`timescale 1ns/1ps
module eeprom_model #(
    parameter logic [47:0] INIT = 48'h0
) (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic        rd_req,
    input  wire logic        wr_req,
    input  wire logic [47:0] wdata,
    output logic      [47:0] rdata,
    output logic             ack
);
    logic [47:0] mem_ff  = INIT;
    logic [11:0] wait_ff = 12'h000;
    logic        ack_ff  = 1'b0;
    assign ack = ack_ff;
    // inverted outside ack so a sample taken at the wrong time shows
    assign rdata = ack_ff ? mem_ff : ~mem_ff;
    always @(posedge clk) begin
        ack_ff <= 1'b0;
        if ((rd_req || wr_req) && !ack_ff) begin
            wait_ff <= wait_ff + 12'h001;
            if (wait_ff >= (slow ? 12'hbb8 : 12'h004)) begin
                ack_ff  <= 1'b1;
                wait_ff <= 12'h000;
                if (!rd_req) begin
                    mem_ff <= wdata;
                end
            end
        end
    end
endmodule // eeprom_model

// ---- test/telemetry_checker_assertions.sv ----
// port assertions for the telemetry and identity command block
`timescale 1ns/1ps
module telemetry_checker (
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic        SCL,
    input wire logic        SDA_IN,
    input wire logic        SDA_OE_N,
    input wire logic        ALERT_N,
    input wire logic        NVM_RD_REQ,
    input wire logic        NVM_WR_REQ,
    input wire logic [47:0] NVM_WDATA,
    input wire logic        NVM_ACK
);
    logic [3:0] idle_ff, nxt_idle;
    logic       scl_ff, sda_ff;
    // cycles since either bus pin last moved
    assign nxt_idle = (SCL != scl_ff || SDA_IN != sda_ff) ? 4'h0 :
                      (idle_ff == 4'hf) ? idle_ff : idle_ff + 4'h1;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            idle_ff <= 4'h0;
            scl_ff  <= 1'b1;
            sda_ff  <= 1'b1;
        end else begin
            idle_ff <= nxt_idle;
            scl_ff  <= SCL;
            sda_ff  <= SDA_IN;
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    ////////////////////////////////////////////////////////////
    reset_quiet_a: assert property ($rose(RSTN) |-> ALERT_N && SDA_OE_N && NVM_RD_REQ
        && !NVM_WR_REQ) else $error("bad outputs after reset");
    load_hold_a: assert property (NVM_RD_REQ && !NVM_ACK |=> NVM_RD_REQ)
        else $error("load request dropped early");
    load_end_a: assert property (NVM_RD_REQ && NVM_ACK |=> !NVM_RD_REQ)
        else $error("load request kept after ack");
    load_once_a: assert property (!NVM_RD_REQ |=> !NVM_RD_REQ)
        else $error("second load without reset");
    store_hold_a: assert property (NVM_WR_REQ && !NVM_ACK |=> NVM_WR_REQ && $stable(NVM_WDATA))
        else $error("store moved while pending");
    store_end_a: assert property (NVM_WR_REQ && !NVM_RD_REQ && NVM_ACK |=> !NVM_WR_REQ)
        else $error("store request kept after ack");
    store_at_stop_a: assert property ($rose(NVM_WR_REQ) |-> SCL && SDA_IN [*1] ##1 SCL)
        else $error("store raised outside a stop");
    idle_quiet_a: assert property (idle_ff >= 4'hc |-> $stable(ALERT_N) && $stable(SDA_OE_N))
        else $error("pin moved on quiet bus");
endmodule // telemetry_checker
bind pmbus_telemetry_ident_regs telemetry_checker chk (.CLK, .RSTN, .SCL, .SDA_IN, .SDA_OE_N,
    .ALERT_N, .NVM_RD_REQ, .NVM_WR_REQ, .NVM_WDATA, .NVM_ACK);

// ---- test/tb_top.sv ----
// self-checking bench for the telemetry and identity command block
`timescale 1ns/1ps
`include "telemetry_params.svh"
module tb_top;
    localparam int          CUR_N  = 2000;
    localparam int          TEMP_N = 600;
    // arbitrary stored identity and model bytes
    localparam logic [47:0] NV     = 48'h3c5a96_a51e2d;
    logic        clk   = 1'b0;
    logic        rstn  = 1'b0;
    logic        scl   = 1'b1;
    logic        hs    = 1'b1;
    logic        slow  = 1'b1;
    logic [7:0]  phase = 8'hff;
    logic [10:0] c0    = 11'h028;
    logic [10:0] c1    = 11'h014;
    logic [10:0] t0    = 11'h7fb;
    logic [10:0] t1    = 11'h7fd;
    logic        sda_o, oe_n, alert_n, nv_rd, nv_wr, nv_ack, a;
    logic [47:0] nv_wd, nv_rdat;
    logic [31:0] v;
    logic [7:0]  ro [3] = '{`CMD_IOUT, `CMD_TEMP, `CMD_REVISION};
    int          failures    = 0;
    int          checks_done = 0;
    int          cyc         = 0;
    int          tick        = 0;
    // open drain line with pull-up
    wire         sda = hs & (oe_n | sda_o);
    pmbus_telemetry_ident_regs #(.CUR_REFRESH_CYC(CUR_N), .TEMP_REFRESH_CYC(TEMP_N)) dut (
        .CLK(clk), .RSTN(rstn), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_N(oe_n),
        .ALERT_N(alert_n), .PHASE(phase), .CUR_PH0(c0), .CUR_PH1(c1), .TEMP_PH0(t0),
        .TEMP_PH1(t1), .NVM_RD_REQ(nv_rd), .NVM_WR_REQ(nv_wr), .NVM_WDATA(nv_wd),
        .NVM_RDATA(nv_rdat), .NVM_ACK(nv_ack));
    eeprom_model #(.INIT(NV)) nvm (.clk(clk), .slow(slow), .rd_req(nv_rd), .wr_req(nv_wr),
        .wdata(nv_wd), .rdata(nv_rdat), .ack(nv_ack));
    ////////////////////////////////////////////////////////////
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        tick <= tick + 1;
        cyc <= rstn ? cyc + 1 : 0;
        if (tick == 60000) begin
            failures++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic chk_flag(input string n, input logic e, input logic g);
        chk_word(n, {31'h0, e}, {31'h0, g});
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one bit: data set while low, sampled late in the high phase
    task automatic bitx(input logic b, output logic r);
        tk(1);
        hs <= b;
        tk(3);
        scl <= 1'b1;
        tk(4);
        r = sda;
        scl <= 1'b0;
    endtask
    // start condition when s is high, stop when low
    task automatic cond(input logic s);
        tk(1);
        hs <= s;
        tk(3);
        scl <= 1'b1;
        tk(4);
        hs <= ~s;
        tk(4);
        if (s) scl <= 1'b0;
    endtask
    task automatic put8(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask
    task automatic wr(input logic [7:0] cmd, input int n, input logic [31:0] d);
        logic x;
        cond(1'b1);
        put8({`DEV_ADDR, 1'b0}, x);
        put8(cmd, x);
        for (int i = 0; i < n; i++) put8(d[8*i +: 8], x);
        cond(1'b0);
    endtask
    // bytes come back low first, packed from bit 0 up
    task automatic rd(input logic [7:0] cmd, input int n, output logic [31:0] d, output logic ak);
        logic r;
        d = 32'h0;
        cond(1'b1);
        put8({`DEV_ADDR, 1'b0}, r);
        put8(cmd, r);
        cond(1'b1);
        put8({`DEV_ADDR, 1'b1}, ak);
        for (int i = 0; i < n * 9 && ak; i++) begin
            bitx(i % 9 == 8 ? i == n * 9 - 1 : 1'b1, r);
            if (i % 9 < 8) d[8*(i/9) + 7 - i%9] = r;
        end
        cond(1'b0);
    endtask
    task automatic rdw(input string n, input logic [7:0] cmd, input int k, input logic [31:0] e);
        rd(cmd, k, v, a);
        chk_word(n, e, v);
    endtask
    task automatic wait_nvm();
        tk(8);
        for (int i = 0; i < 4000 && (nv_rd || nv_wr); i++) tk(1);
        chk_flag("eeprom idle", 1'b0, nv_rd | nv_wr);
    endtask
    task automatic tel(input logic [7:0] p, input logic [10:0] a0, a1, b0, b1,
                       input logic [15:0] ec, et);
        phase <= p;
        c0 <= a0;
        c1 <= a1;
        t0 <= b0;
        t1 <= b1;
        tk(CUR_N + 8);
        rdw("current word", `CMD_IOUT, 2, {16'h0, ec});
        rdw("temperature word", `CMD_TEMP, 2, {16'h0, et});
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        tk(3);
        rstn <= 1'b1;
        tk(3);
        rd(`CMD_MFR_IDENT, 4, v, a);
        chk_flag("early address ack", 1'b0, a);
        wait_nvm();
        slow <= 1'b0;
        rdw("identity load", `CMD_MFR_IDENT, 4, {NV[23:0], 8'h03});
        rdw("model load", `CMD_MAKER_MODEL_BYTES, 4, {NV[47:24], 8'h03});
        $display("test load done");
        tel(8'hff, 11'h028, 11'h014, 11'h7fb, 11'h7fd, 16'hf03c, 16'h07fd);
        tel(8'hff, 11'h3ff, 11'h3ff, 11'h01e, 11'h7fe, 16'hfbff, 16'h001e);
        tel(8'h01, 11'h7f8, 11'h014, 11'h01e, 11'h7fe, 16'hf014, 16'h07fe);
        tel(8'h82, 11'h7f8, 11'h014, 11'h01e, 11'h7fe, 16'hf7f8, 16'h001e);
        $display("test phase done");
        while (cyc % CUR_N != 5) tk(1);
        c0 <= 11'h064;
        rdw("stale current", `CMD_IOUT, 2, 32'h0000f7f8);
        tk(CUR_N);
        rdw("fresh current", `CMD_IOUT, 2, 32'h0000f064);
        while (cyc % TEMP_N != 5) tk(1);
        t0 <= 11'h050;
        rdw("stale temperature", `CMD_TEMP, 2, 32'h0000001e);
        tk(TEMP_N);
        rdw("fresh temperature", `CMD_TEMP, 2, 32'h00000050);
        $display("test refresh done");
        foreach (ro[i]) begin
            wr(ro[i], 2, 32'h00001234);
            tk(4);
            chk_flag("alert after write", 1'b0, alert_n);
            rdw("invalid command bit", `CMD_STATUS_CML, 1, 32'(1) << `CML_IVC_BIT);
            rdw("summary fault bit", `CMD_STATUS_BYTE, 1, 32'(1) << `STATUS_CML_BIT);
            wr(`CMD_STATUS_CML, 1, 32'h00000080);
            tk(4);
            chk_flag("alert cleared", 1'b1, alert_n);
            rdw("invalid bit cleared", `CMD_STATUS_CML, 1, 32'h0);
        end
        rdw("revision byte", `CMD_REVISION, 1, {24'h0, `PART_ONE_REV, `PART_TWO_REV});
        $display("test read-only done");
        wr(`CMD_MFR_IDENT, 4, 32'h13579b03);
        wait_nvm();
        wr(`CMD_MAKER_MODEL_BYTES, 4, 32'h2468ac03);
        wait_nvm();
        wr(`CMD_MFR_IDENT, 3, 32'h00bbcc02);
        rdw("identity after short block", `CMD_MFR_IDENT, 4, 32'h13579b03);
        rstn <= 1'b0;
        tk(3);
        rstn <= 1'b1;
        wait_nvm();
        rdw("identity kept", `CMD_MFR_IDENT, 4, 32'h13579b03);
        rdw("model kept", `CMD_MAKER_MODEL_BYTES, 4, 32'h2468ac03);
        $display("test identity done");
        finish_test();
    end
endmodule // tb_top
